// *** status_cfg.svh ***
/*
 * constants for the status transfer and program counter write block:
 * status word layout, masks, mode codes, reset value, cycle figures.
 * assumes it is included by bare name wherever these are needed.
 */
`ifndef STATUS_CFG_SVH
`define STATUS_CFG_SVH

// ****************************************************************
// status word layout
// ****************************************************************
`define BIT_NEG            31
`define BIT_ZERO           30
`define BIT_CARRY          29
`define BIT_OVFL           28
`define SW_DEFINED_MASK    32'hF000_00DF
`define SW_FLAGS_MASK      32'hF000_0000
`define SW_RESET_VALUE     32'h0000_00D3
`define SAVED_RESET_VALUE  32'h0000_0000

// ****************************************************************
// mode field codes
// ****************************************************************
`define MODE_USER          5'h10
`define MODE_FIQ           5'h11
`define MODE_IRQ           5'h12
`define MODE_SVC           5'h13
`define MODE_ABT           5'h17
`define MODE_UND           5'h1B
`define SAVED_BANKS        5

// ****************************************************************
// program counter and cycle figures
// ****************************************************************
`define PC_INDEX           4'hF
`define PC_AHEAD_IMM_SHIFT 32'h0000_0008
`define PC_AHEAD_REG_SHIFT 32'h0000_000C
`define CYC_ZERO           2'h0
`define CYC_ONE            2'h1
`define CYC_TWO            2'h2

`endif

// *** status_pkg.sv ***
/*
 * types shared by the status transfer block and its saved word bank.
 * assumes status_cfg.svh sits in the same folder.
 */
`include "status_cfg.svh"

package status_pkg;

  typedef logic [31:0] word_t;

  typedef struct packed {
    logic [`SAVED_BANKS-1:0][31:0] words;
  } bank_state_t;

  typedef struct packed {
    word_t      curWord;
    logic       regWrEn;
    logic [3:0] regWrIdx;
    word_t      regWrData;
    logic       pcWrEn;
    word_t      pcWrData;
    word_t      pcOperand;
    logic [1:0] seqCycles;
    logic [1:0] nonseqCycles;
    logic [1:0] internalCycles;
    logic       execDone;
    logic       flagsSet;
  } exec_state_t;

endpackage

// *** saved_word_bank.sv ***
/*
 * banked saved status words, one per privileged mode.
 * assumes the caller presents the current mode and masked writes.
 */
`timescale 1ns/1ps
`include "status_cfg.svh"

module saved_word_bank import status_pkg::*; (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [4:0] mode,
  input  wire logic       wrEn,
  input  wire word_t      wrMask,
  input  wire word_t      wrData,
  output word_t           rdData,
  output logic            present
);

  bank_state_t st_reg;
  bank_state_t st_next;
  logic [2:0]  idx;
  logic [3:0]  slot;

  // ****************************************************************
  // mode to bank slot
  // ****************************************************************
  function automatic logic [3:0] slotOf(input logic [4:0] m);
    case (m)
      `MODE_FIQ: slotOf = 4'h8;
      `MODE_IRQ: slotOf = 4'h9;
      `MODE_SVC: slotOf = 4'hA;
      `MODE_ABT: slotOf = 4'hB;
      `MODE_UND: slotOf = 4'hC;
      default:   slotOf = 4'h0;
    endcase
  endfunction

  // user and unknown modes own no copy
  assign slot    = slotOf(mode);
  assign present = slot[3];
  assign idx     = slot[2:0];
  assign rdData  = present ? st_reg.words[idx] : '0;

  always_comb begin
    st_next = st_reg;
    if (wrEn && present) begin
      st_next.words[idx] = (st_reg.words[idx] & ~wrMask)
                         | (wrData & wrMask & `SW_DEFINED_MASK);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= {`SAVED_BANKS{`SAVED_RESET_VALUE}};
    end else begin
      st_reg <= st_next;
    end
  end

endmodule // saved_word_bank

// *** status_exec_ctrl.sv ***
/*
 * execution control for data processing writes to the program counter
 * and for status word transfers, holding the current status word.
 * assumes an outside alu supplies result and carry/overflow, and that
 * the register file takes the write strobe one cycle after issue.
 */
// Contract
// - execute only when condition field passes
// - non-pc destination may update flags if set
// - zero flag from zero result, negative bit 31
// - pc destination without set: status untouched
// - pc destination with set: restore saved word
// - pc operand is address plus 8 or 12
// - test and compare ops write no register
// - legacy test form restores saved if privileged
// - reg shift, pc write cycle counts
// - status transfers hide in unset test encodings
// - status read copies whole selected word
// - status write copies register to selected word
// - flags-only write touches only top four bits
// - source bits 31..28 go to n z c v
// - user mode may change flags only
// - saved word is the current mode's copy
// - user mode has no saved word
// - only eleven status bits are defined
// - whole and flag selectors for both words
// - every status transfer takes one s cycle
`timescale 1ns/1ps
`include "status_cfg.svh"

module status_exec_ctrl import status_pkg::*; (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       instrValid,
  input  wire word_t      instr,
  input  wire word_t      instrAddr,
  input  wire word_t      aluResult,
  input  wire logic       aluCarry,
  input  wire logic       aluOverflow,
  input  wire word_t      sourceVal,
  output word_t           currentStatusWord,
  output logic            regWrEn,
  output logic [3:0]      regWrIdx,
  output word_t           regWrData,
  output logic            pcWrEn,
  output word_t           pcWrData,
  output word_t           pcOperand,
  output logic [1:0]      seqCycles,
  output logic [1:0]      nonseqCycles,
  output logic [1:0]      internalCycles,
  output logic            execDone
);

  exec_state_t st_reg;
  exec_state_t st_next;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  logic  condOk;
  logic  isDp;
  logic  testOp;
  logic  setFlags;
  logic  pcDest;
  logic  regShift;
  logic  isStatus;
  logic  isRead;
  logic  isWrite;
  logic  flagsOnly;
  logic  useSaved;
  logic  privileged;
  logic  hasSaved;
  logic  bankWrEn;
  word_t bankWrMask;
  word_t writeSrc;
  word_t savedWord;
  word_t writeMask;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic condPass(input logic [3:0] c,
                                    input logic [3:0] f);
    logic n;
    logic z;
    logic cy;
    logic v;
    {n, z, cy, v} = f;
    case (c)
      4'h0:    condPass = z;
      4'h1:    condPass = !z;
      4'h2:    condPass = cy;
      4'h3:    condPass = !cy;
      4'h4:    condPass = n;
      4'h5:    condPass = !n;
      4'h6:    condPass = v;
      4'h7:    condPass = !v;
      4'h8:    condPass = cy && !z;
      4'h9:    condPass = !cy || z;
      4'hA:    condPass = n == v;
      4'hB:    condPass = n != v;
      4'hC:    condPass = !z && (n == v);
      4'hD:    condPass = z || (n != v);
      4'hE:    condPass = 1'b1;
      default: condPass = 1'b0; // reserved code treated as never
    endcase
  endfunction

  function automatic word_t rotImm(input logic [11:0] f);
    logic [63:0] dbl;
    dbl = {24'h00_0000, f[7:0], 24'h00_0000, f[7:0]} >> {f[11:8], 1'b0};
    rotImm = dbl[31:0];
  endfunction

  // logical class keeps overflow untouched
  function automatic logic isLogical(input logic [3:0] op);
    case (op)
      4'h0, 4'h1, 4'h8, 4'h9, 4'hC, 4'hD, 4'hE, 4'hF: isLogical = 1'b1;
      default:                                      isLogical = 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // decode
  // ****************************************************************
  assign condOk    = condPass(instr[31:28], st_reg.curWord[31:28]);
  // multiplies share the space; bit 7 and bit 4 both set with bit 25 clear excludes them
  assign isDp      = (instr[27:26] == 2'b00)
                   && !(!instr[25] && instr[7] && instr[4]);
  assign testOp    = instr[24:23] == 2'b10;
  assign setFlags  = instr[20];
  assign pcDest    = instr[15:12] == `PC_INDEX;
  assign regShift  = !instr[25] && instr[4];
  assign isStatus  = isDp && testOp && !setFlags;
  assign isRead    = isStatus && !instr[21];
  assign isWrite   = isStatus && instr[21];
  assign flagsOnly = !instr[16];
  assign useSaved  = instr[22];
  assign privileged = st_reg.curWord[4:0] != `MODE_USER;
  assign writeSrc  = instr[25] ? rotImm(instr[11:0]) : sourceVal;
  // user mode loses control bits even on a whole-word write
  assign writeMask = (flagsOnly || !privileged) ? `SW_FLAGS_MASK
                                                : `SW_DEFINED_MASK;

  saved_word_bank u_bank (
    .clk     (clk),
    .srst    (srst),
    .mode    (st_reg.curWord[4:0]),
    .wrEn    (bankWrEn),
    .wrMask  (bankWrMask),
    .wrData  (writeSrc),
    .rdData  (savedWord),
    .present (hasSaved)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_next                = st_reg;
    st_next.regWrEn        = 1'b0;
    st_next.pcWrEn         = 1'b0;
    st_next.execDone       = 1'b0;
    st_next.flagsSet       = 1'b0;
    bankWrEn               = 1'b0;
    bankWrMask             = `SW_FLAGS_MASK;
    if (instrValid) begin
      st_next.execDone       = 1'b1;
      st_next.regWrIdx       = instr[15:12];
      st_next.pcOperand      = instrAddr
                             + (regShift ? `PC_AHEAD_REG_SHIFT
                                         : `PC_AHEAD_IMM_SHIFT);
      st_next.seqCycles      = `CYC_ONE;
      st_next.nonseqCycles   = `CYC_ZERO;
      st_next.internalCycles = `CYC_ZERO;
      if (condOk) begin
        if (isRead) begin
          st_next.regWrEn   = 1'b1;
          st_next.regWrData = useSaved ? savedWord : st_reg.curWord;
        end else if (isWrite) begin
          if (!useSaved) begin
            st_next.curWord = (st_reg.curWord & ~writeMask)
                            | (writeSrc & writeMask);
          end else begin
            bankWrEn   = 1'b1;
            bankWrMask = flagsOnly ? `SW_FLAGS_MASK
                                   : `SW_DEFINED_MASK;
          end
        end else if (isDp) begin
          st_next.regWrData = aluResult;
          if (regShift) begin
            st_next.internalCycles = `CYC_ONE;
          end
          if (testOp && pcDest) begin
            // old test form: restore only, never flags
            if (privileged && hasSaved) begin
              st_next.curWord = savedWord & `SW_DEFINED_MASK;
            end
          end else if (pcDest && !testOp) begin
            st_next.pcWrEn       = 1'b1;
            st_next.pcWrData     = aluResult;
            st_next.seqCycles    = `CYC_TWO;
            st_next.nonseqCycles = `CYC_ONE;
            if (setFlags && privileged && hasSaved) begin
              st_next.curWord = savedWord & `SW_DEFINED_MASK;
            end
          end else begin
            st_next.regWrEn = !testOp;
            if (setFlags) begin
              st_next.flagsSet = 1'b1;
              st_next.curWord[`BIT_NEG]   = aluResult[31];
              st_next.curWord[`BIT_ZERO]  = aluResult == 32'h0000_0000;
              st_next.curWord[`BIT_CARRY] = aluCarry;
              if (!isLogical(instr[24:21])) begin
                st_next.curWord[`BIT_OVFL] = aluOverflow;
              end
            end
          end
        end
      end
    end
    st_next.curWord = st_next.curWord & `SW_DEFINED_MASK;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg         <= '0;
      st_reg.curWord <= `SW_RESET_VALUE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign currentStatusWord = st_reg.curWord;
  assign regWrEn           = st_reg.regWrEn;
  assign regWrIdx          = st_reg.regWrIdx;
  assign regWrData         = st_reg.regWrData;
  assign pcWrEn            = st_reg.pcWrEn;
  assign pcWrData          = st_reg.pcWrData;
  assign pcOperand         = st_reg.pcOperand;
  assign seqCycles         = st_reg.seqCycles;
  assign nonseqCycles      = st_reg.nonseqCycles;
  assign internalCycles    = st_reg.internalCycles;
  assign execDone          = st_reg.execDone;

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_cond_skip_quiet: assert property (
    instrValid && !condOk |=> !regWrEn && !pcWrEn
                              && $stable(currentStatusWord))
    else $error("failed condition still changed state");

  chk_pc_operand_ahead: assert property (
    instrValid |=> pcOperand == $past(instrAddr)
      + ($past(regShift) ? 32'h0000_000C : 32'h0000_0008))
    else $error("pc operand offset wrong");

  chk_flag_result_match: assert property (
    st_reg.flagsSet |-> currentStatusWord[31] == regWrData[31]
      && currentStatusWord[30] == (regWrData == 32'h0000_0000))
    else $error("n or z flag does not match result");

  chk_test_no_write: assert property (
    instrValid && condOk && isDp && testOp && setFlags && !pcDest
      |=> !regWrEn && st_reg.flagsSet)
    else $error("test op wrote a register or skipped flags");

  chk_pc_plain_write: assert property (
    instrValid && condOk && isDp && !testOp && pcDest && !setFlags
      |=> pcWrEn && pcWrData == $past(aluResult)
          && $stable(currentStatusWord) && !regWrEn)
    else $error("plain pc write disturbed status");

  chk_pc_restore_word: assert property (
    instrValid && condOk && isDp && !testOp && pcDest && setFlags
      && privileged && hasSaved
      |=> pcWrEn && currentStatusWord
          == ($past(savedWord) & 32'hF000_00DF))
    else $error("pc write with set did not restore");

  chk_user_ctrl_kept: assert property (
    instrValid && !privileged
      |=> currentStatusWord[27:0] == $past(currentStatusWord[27:0]))
    else $error("user mode changed control bits");

  chk_reserved_zero: assert property (
    instrValid |=> (currentStatusWord & 32'h0FFF_FF20) == 32'h0000_0000)
    else $error("reserved status bits not zero");

  chk_pc_write_cycles: assert property (
    pcWrEn |-> seqCycles == 2'h2 && nonseqCycles == 2'h1)
    else $error("pc write cycle count wrong");

  chk_status_one_cycle: assert property (
    instrValid && isStatus |=> execDone && seqCycles == 2'h1
      && nonseqCycles == 2'h0 && internalCycles == 2'h0)
    else $error("status transfer not one s cycle");

  chk_read_copies_word: assert property (
    instrValid && condOk && isRead && !useSaved
      |=> regWrEn && regWrData == $past(currentStatusWord))
    else $error("status read copied wrong value");

endmodule // status_exec_ctrl

// *** status_transfer_and_pc_write_tb.sv ***
/*
 * self-checking bench for status_exec_ctrl: flag updates, program
 * counter writes, test ops, condition skip, status transfers, modes.
 * assumes status_pkg and status_cfg.svh compiled alongside.
 */
`timescale 1ns/1ps
`include "status_cfg.svh"

module status_transfer_and_pc_write_tb import status_pkg::*;;
  logic       clk;
  logic       srst;
  logic       instrValid;
  word_t      instr;
  word_t      instrAddr;
  word_t      aluResult;
  logic       aluCarry;
  logic       aluOverflow;
  word_t      sourceVal;
  word_t      currentStatusWord;
  logic       regWrEn;
  logic [3:0] regWrIdx;
  word_t      regWrData;
  logic       pcWrEn;
  word_t      pcWrData;
  word_t      pcOperand;
  logic [1:0] seqCycles;
  logic [1:0] nonseqCycles;
  logic [1:0] internalCycles;
  logic       execDone;
  int         nMismatch;
  int         testsRun;

  status_exec_ctrl DUT (
    .clk              (clk),
    .srst             (srst),
    .instrValid       (instrValid),
    .instr            (instr),
    .instrAddr        (instrAddr),
    .aluResult        (aluResult),
    .aluCarry         (aluCarry),
    .aluOverflow      (aluOverflow),
    .sourceVal        (sourceVal),
    .currentStatusWord(currentStatusWord),
    .regWrEn          (regWrEn),
    .regWrIdx         (regWrIdx),
    .regWrData        (regWrData),
    .pcWrEn           (pcWrEn),
    .pcWrData         (pcWrData),
    .pcOperand        (pcOperand),
    .seqCycles        (seqCycles),
    .nonseqCycles     (nonseqCycles),
    .internalCycles   (internalCycles),
    .execDone         (execDone)
  );

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input string n, input word_t e, input word_t g);
    testsRun++;
    if (g !== e) begin
      nMismatch++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // inputs move on falling edges only; answer waited for, bounded
  task automatic issue(input word_t ins, input word_t res,
                       input logic cy, input logic ov, input word_t src);
    int n;
    @(negedge clk);
    instrValid = 1'b1;
    instr = ins;
    aluResult = res;
    aluCarry = cy;
    aluOverflow = ov;
    sourceVal = src;
    instrAddr = instrAddr + 32'h0000_0004;
    @(negedge clk);
    instrValid = 1'b0;
    n = 0;
    while (execDone !== 1'b1 && n < 3) begin
      @(negedge clk);
      n++;
    end
    chk("execDone", 1'h1, execDone);
  endtask

  task automatic st(input word_t e);
    chk("status", e, currentStatusWord);
  endtask

  task automatic cyc(input logic [5:0] e);
    chk("cycles", e, {seqCycles, nonseqCycles, internalCycles});
  endtask

  task automatic rd(input word_t ins, input word_t e);
    issue(ins, 32'h0000_0000, 1'b0, 1'b0, 32'h0000_0000);
    chk("regWrEn", 1'h1, regWrEn);
    chk("regWrData", e, regWrData);
  endtask

  task automatic wr(input word_t ins, input word_t src);
    issue(ins, 32'h0000_0000, 1'b0, 1'b0, src);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_flags();
    issue(32'hE090_2000, 32'h0000_0000, 1'b1, 1'b0, 32'h0000_0000);
    chk("regWrIdx", 4'h2, regWrIdx);
    st(32'h6000_00D3);
    chk("pcOperand", instrAddr + 32'h0000_0008, pcOperand);
    cyc({2'h1, 2'h0, 2'h0});
    issue(32'hE090_2000, 32'h8000_0000, 1'b0, 1'b1, 32'h0000_0000);
    st(32'h9000_00D3);
    // register shift without set bit: flags must hold
    issue(32'hE080_2110, 32'h0000_0055, 1'b1, 1'b0, 32'h0000_0000);
    chk("pcOperand", instrAddr + 32'h0000_000C, pcOperand);
    cyc({2'h1, 2'h0, 2'h1});
    st(32'h9000_00D3);
    // strobes are one-cycle pulses
    @(negedge clk);
    chk("execDone", 1'h0, execDone);
    chk("regWrEn", 1'h0, regWrEn);
  endtask

  task automatic t_pcwrite();
    issue(32'hE1A0_F000, 32'h0000_1000, 1'b1, 1'b1, 32'h0000_0000);
    chk("pcWrEn", 1'h1, pcWrEn);
    chk("pcWrData", 32'h0000_1000, pcWrData);
    chk("regWrEn", 1'h0, regWrEn);
    st(32'h9000_00D3);
    cyc({2'h2, 2'h1, 2'h0});
    issue(32'hE1A0_F110, 32'h0000_2000, 1'b0, 1'b0, 32'h0000_0000);
    cyc({2'h2, 2'h1, 2'h1});
    chk("pcOperand", instrAddr + 32'h0000_000C, pcOperand);
  endtask

  task automatic t_tests();
    // logical tests keep overflow, compares clear it
    word_t e[4] = '{32'h5000_00D3, 32'h5000_00D3,
                    32'h4000_00D3, 32'h4000_00D3};
    for (int i = 0; i < 4; i++) begin
      issue(32'hE110_3000 | (i << 21), 32'h0000_0000, 1'b0, 1'b0,
            32'h0000_0000);
      chk("regWrEn", 1'h0, regWrEn);
      st(e[i]);
    end
  endtask

  task automatic t_cond();
    issue(32'h1090_2000, 32'h8000_0000, 1'b1, 1'b1, 32'h0000_0000);
    chk("regWrEn", 1'h0, regWrEn);
    st(32'h4000_00D3);
    issue(32'hF1A0_F000, 32'h0000_3000, 1'b1, 1'b1, 32'h0000_0000);
    chk("pcWrEn", 1'h0, pcWrEn);
    issue(32'h0080_4000, 32'h0000_0077, 1'b0, 1'b0, 32'h0000_0000);
    chk("regWrData", 32'h0000_0077, regWrData);
  endtask

  // condition codes 0 to 14 against two flag settings
  task automatic t_condall();
    logic [15:0] pass [2] = '{16'h565A, 16'h66A5};
    word_t       fl [2]   = '{32'hE328_F490, 32'hE328_F460};
    for (int k = 0; k < 2; k++) begin
      wr(fl[k], 32'h0000_0000);
      for (int c = 0; c < 15; c++) begin
        issue(32'h0080_7000 | (c << 28), 32'h0000_0000, 1'b0, 1'b0,
              32'h0000_0000);
        chk("regWrEn", pass[k][c], regWrEn);
      end
    end
  endtask

  task automatic t_transfer();
    wr(32'hE328_F4A0, 32'h0000_0000);
    st(32'hA000_00D3);
    cyc({2'h1, 2'h0, 2'h0});
    rd(32'hE10F_5000, 32'hA000_00D3);
    chk("regWrIdx", 4'h5, regWrIdx);
    wr(32'hE169_F000, 32'hAFFF_FF33);
    rd(32'hE14F_6000, 32'hA000_0013);
    wr(32'hE168_F000, 32'h5123_4567);
    rd(32'hE14F_6000, 32'h5000_0013);
    wr(32'hE129_F000, 32'h0000_00D1);
    st(32'h0000_00D1);
    rd(32'hE14F_6000, 32'h0000_0000);
    wr(32'hE169_F000, 32'h2000_00D2);
    rd(32'hE14F_6000, 32'h2000_00D2);
    wr(32'hE129_F000, 32'h0000_00D3);
    rd(32'hE14F_6000, 32'h5000_0013);
  endtask

  task automatic t_restore();
    wr(32'hE130_F000, 32'h0000_0000);
    st(32'h5000_0013);
    chk("pcWrEn", 1'h0, pcWrEn);
    wr(32'hE169_F000, 32'h8000_0010);
    issue(32'hE1B0_F000, 32'h0000_2000, 1'b0, 1'b0, 32'h0000_0000);
    chk("pcWrEn", 1'h1, pcWrEn);
    st(32'h8000_0010);
  endtask

  task automatic t_user();
    wr(32'hE129_F000, 32'h3000_00D3);
    st(32'h3000_0010);
    wr(32'hE169_F000, 32'hFFFF_FFFF);
    rd(32'hE14F_6000, 32'h0000_0000);
    wr(32'hE130_F000, 32'h0000_0000);
    st(32'h3000_0010);
    issue(32'hE1B0_F000, 32'h0000_4000, 1'b0, 1'b0, 32'h0000_0000);
    chk("pcWrData", 32'h0000_4000, pcWrData);
    st(32'h3000_0010);
  endtask

  // ****************************************************************
  // run control
  // ****************************************************************
  task automatic stop_test();
    if (nMismatch == 0 && testsRun > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // generous: about 60 issues of a few cycles each
  initial begin
    #100000;
    nMismatch++;
    stop_test();
  end

  initial begin
    nMismatch = 0;
    testsRun = 0;
    srst = 1'b1;
    instrValid = 1'b0;
    instr = 32'h0000_0000;
    instrAddr = 32'h0000_0100;
    aluResult = 32'h0000_0000;
    aluCarry = 1'b0;
    aluOverflow = 1'b0;
    sourceVal = 32'h0000_0000;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    st(`SW_RESET_VALUE);
    chk("regWrEn", 1'h0, regWrEn);
    t_flags();
    t_pcwrite();
    t_tests();
    t_cond();
    t_condall();
    t_transfer();
    t_restore();
    t_user();
    stop_test();
  end
endmodule // status_transfer_and_pc_write_tb
